// *** include/mau_if.sv ***
// Connection between the issuing pipeline and the multiply-accumulate unit
`timescale 1ns/1ns
interface mau_if;
  import mau_pkg::*;
  logic mac_valid;
  logic [31:0] mac_instr;
  logic [31:0] mac_src_a;
  logic [31:0] mac_src_b;
  logic mac_ready;
  logic acc_valid;
  mau_acc_op_type acc_op;
  logic [31:0] acc_wr_data;
  logic mac_done;
  logic [4:0] mac_dest;
  logic [31:0] mac_dest_data;
  logic mac_illegal;
  logic ovf_exc;
  logic [31:0] acc_upper_word;
  logic [31:0] acc_bottom_word;

  modport unit (
    input mac_valid, mac_instr, mac_src_a, mac_src_b, acc_valid, acc_op, acc_wr_data,
    output mac_ready, mac_done, mac_dest, mac_dest_data, mac_illegal, ovf_exc,
    output acc_upper_word, acc_bottom_word
  );
  modport issuer (
    output mac_valid, mac_instr, mac_src_a, mac_src_b, acc_valid, acc_op, acc_wr_data,
    input mac_ready, mac_done, mac_dest, mac_dest_data, mac_illegal, ovf_exc,
    input acc_upper_word, acc_bottom_word
  );
endinterface

// *** include/mau_pkg.sv ***
// Constants, types and shared functions of the multiply-accumulate unit
// Notes on behaviour
// RULE1 - Eight variants from three single-bit instruction fields
// RULE2 - Clamping mode: operands are 16-bit, by unsigned_select
// RULE3 - Clamping mode: 32-bit add to accumulator low bits
// RULE4 - Clamping mode: clamp sum, load both accumulator words
// RULE5 - Issuer extends operand bits above bit 15
// RULE6 - Issuer keeps accumulator extended above 32 bits
// RULE7 - Destination gets upper or bottom word per select
// RULE8 - Never raise an overflow exception
// RULE9 - Plain mode: operands are full 32-bit values
// RULE10 - Plain mode: 64-bit add to full accumulator
// RULE11 - Plain mode: sum low/high words to bottom/upper
// RULE12 - Plain mode: no clamping on overflow or underflow
// RULE13 - Spacing 1/3/36/68 after multiply and divide forms
// RULE14 - Spacing 2 after reads, 0 after writes/accumulates
// RULE15 - Accumulator and destination update together, back to back
package mau_pkg;

  // ==========================================================
  // Instruction word layout
  localparam int INSTR_W = 32;
  localparam int FUNCT_LSB = 0;
  localparam int FUNCT_W = 6;
  localparam logic [5:0] FUNCT_MUL_ACC = 6'h28;
  localparam int UNSIGNED_SELECT_BIT = 6;
  localparam int ZERO_FIELD_LSB = 7;
  localparam int ZERO_FIELD_W = 2;
  localparam int UPPER_DEST_SELECT_BIT = 9;
  localparam int SAT_SELECT_BIT = 10;
  localparam int DEST_LSB = 11;
  localparam int DEST_W = 5;

  // ==========================================================
  // Accumulator and clamp values
  localparam int WORD_W = 32;
  localparam int NARROW_W = 16;
  localparam logic [31:0] ACC_UPPER_RST = 32'h0000_0000;
  localparam logic [31:0] ACC_BOTTOM_RST = 32'h0000_0000;
  localparam logic [63:0] CLAMP_SIGNED_OVF = 64'h0000_0000_7fff_ffff;
  localparam logic [63:0] CLAMP_SIGNED_UNF = 64'hffff_ffff_8000_0000;
  localparam logic [63:0] CLAMP_UNSIGNED_OVF = 64'hffff_ffff_ffff_ffff;

  // ==========================================================
  // Other accumulator instructions seen by the unit
  typedef enum logic [2:0] {
    ACC_SIGNED_MULTIPLY_32 = 3'b000,
    ACC_DOUBLEWORD_MULTIPLY = 3'b001,
    ACC_DIVIDE_32 = 3'b010,
    ACC_DOUBLEWORD_DIVIDE = 3'b011,
    ACC_READ_UPPER_ACC = 3'b100,
    ACC_READ_BOTTOM_ACC = 3'b101,
    ACC_WRITE_UPPER_ACC = 3'b110,
    ACC_WRITE_BOTTOM_ACC = 3'b111
  } mau_acc_op_type;

  // ==========================================================
  // Hazard spacing in cycles
  localparam int HAZ_W = 7;
  localparam logic [6:0] HAZ_MULTIPLY_32 = 7'h01;
  localparam logic [6:0] HAZ_DOUBLEWORD_MULTIPLY = 7'h03;
  localparam logic [6:0] HAZ_DIVIDE_32 = 7'h24;
  localparam logic [6:0] HAZ_DOUBLEWORD_DIVIDE = 7'h44;
  localparam logic [6:0] HAZ_READ_ACC = 7'h02;
  localparam logic [6:0] HAZ_WRITE_ACC = 7'h00;

  // Spacing owed before the next accumulate
  function automatic logic [6:0] mau_spacing(input mau_acc_op_type op);
    logic [6:0] n;
    n = HAZ_WRITE_ACC;
    unique case (op)
      ACC_SIGNED_MULTIPLY_32: n = HAZ_MULTIPLY_32; // RULE13
      ACC_DOUBLEWORD_MULTIPLY: n = HAZ_DOUBLEWORD_MULTIPLY; // RULE13
      ACC_DIVIDE_32: n = HAZ_DIVIDE_32; // RULE13
      ACC_DOUBLEWORD_DIVIDE: n = HAZ_DOUBLEWORD_DIVIDE; // RULE13
      ACC_READ_UPPER_ACC, ACC_READ_BOTTOM_ACC: n = HAZ_READ_ACC; // RULE14
      ACC_WRITE_UPPER_ACC, ACC_WRITE_BOTTOM_ACC: n = HAZ_WRITE_ACC; // RULE14
    endcase
    return n;
  endfunction

  // Next value of a spacing counter
  function automatic logic [6:0] mau_count_next(input logic load, input mau_acc_op_type op,
                                                input logic [6:0] cnt);
    logic [6:0] n;
    n = cnt;
    if (load) begin
      n = mau_spacing(op);
    end else if (cnt != 7'h00) begin
      n = cnt - 7'h01;
    end
    return n;
  endfunction

endpackage

// *** rtl/mau_core.sv ***
// Multiply-accumulate datapath with the accumulator pair
`timescale 1ns/1ns
module mau_core
  import mau_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  mau_if.unit bus,
  output logic [31:0] acc_upper_word,
  output logic [31:0] acc_bottom_word
);

  // ==========================================================
  // Helpers
  function automatic logic [31:0] ext16(input logic [15:0] v, input logic uns);
    return uns ? {16'h0000, v} : {{16{v[15]}}, v};
  endfunction

  logic [31:0] upper_r;
  logic [31:0] bottom_r;
  logic [6:0] haz_cnt_r;
  logic [6:0] haz_cnt_nxt;
  logic ready_r;
  logic done_r;
  logic illegal_r;
  logic [4:0] dest_r;
  logic [31:0] dest_data_r;

  // ==========================================================
  // Decode
  logic sat_sel;
  logic upper_dest_select;
  logic unsigned_select;
  logic well_formed;
  logic take;
  logic take_ok;
  assign sat_sel = bus.mac_instr[SAT_SELECT_BIT]; // RULE1
  assign upper_dest_select = bus.mac_instr[UPPER_DEST_SELECT_BIT]; // RULE1
  assign unsigned_select = bus.mac_instr[UNSIGNED_SELECT_BIT]; // RULE1
  // Bad function code or nonzero spare bits is not an accumulate at all
  assign well_formed = (bus.mac_instr[FUNCT_LSB +: FUNCT_W] == FUNCT_MUL_ACC)
                       && (bus.mac_instr[ZERO_FIELD_LSB +: ZERO_FIELD_W] == 2'b00); // RULE1
  // Other accumulator traffic in the same cycle wins; accumulate is refused
  assign take = bus.mac_valid && ready_r && !bus.acc_valid;
  assign take_ok = take && well_formed;

  // ==========================================================
  // Clamping arithmetic
  logic [31:0] nar_a;
  logic [31:0] nar_b;
  logic [31:0] nar_prod;
  logic [32:0] nar_sum;
  logic [63:0] nar_res;
  always_comb begin
    nar_a = ext16(bus.mac_src_a[15:0], unsigned_select); // RULE2 RULE5
    nar_b = ext16(bus.mac_src_b[15:0], unsigned_select); // RULE2
    if (unsigned_select) begin
      nar_prod = nar_a * nar_b;
      nar_sum = {1'b0, nar_prod} + {1'b0, bottom_r}; // RULE3 RULE6
    end else begin
      nar_prod = 32'($signed(nar_a) * $signed(nar_b));
      nar_sum = {nar_prod[31], nar_prod} + {bottom_r[31], bottom_r}; // RULE3
    end
    if (unsigned_select) begin
      if (nar_sum[32]) begin
        nar_res = CLAMP_UNSIGNED_OVF; // RULE4
      end else begin
        nar_res = {32'h0000_0000, nar_sum[31:0]};
      end
    end else if (nar_sum[32] != nar_sum[31]) begin
      // Sign of the 33-bit sum tells overflow from underflow
      nar_res = nar_sum[32] ? CLAMP_SIGNED_UNF : CLAMP_SIGNED_OVF; // RULE4
    end else begin
      nar_res = {{32{nar_sum[31]}}, nar_sum[31:0]};
    end
  end

  // ==========================================================
  // Plain arithmetic
  logic [63:0] wide_prod;
  logic [63:0] wide_res;
  always_comb begin
    if (unsigned_select) begin
      wide_prod = {32'h0000_0000, bus.mac_src_a} * {32'h0000_0000, bus.mac_src_b}; // RULE9
    end else begin
      wide_prod = 64'($signed(bus.mac_src_a) * $signed(bus.mac_src_b)); // RULE9
    end
    // Modulo 2^64: wraps silently, same bits for signed and unsigned
    wide_res = wide_prod + {upper_r, bottom_r}; // RULE10 RULE12
  end

  logic [63:0] result;
  assign result = sat_sel ? nar_res : wide_res;

  // ==========================================================
  // Accumulator pair
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      upper_r <= ACC_UPPER_RST;
      bottom_r <= ACC_BOTTOM_RST;
    end else if (bus.acc_valid && bus.acc_op == ACC_WRITE_UPPER_ACC) begin
      upper_r <= bus.acc_wr_data;
    end else if (bus.acc_valid && bus.acc_op == ACC_WRITE_BOTTOM_ACC) begin
      bottom_r <= bus.acc_wr_data;
    end else if (take_ok) begin
      upper_r <= result[63:32]; // RULE11 RULE4 RULE15
      bottom_r <= result[31:0]; // RULE11 RULE4 RULE15
    end
  end

  // ==========================================================
  // Destination write, same edge as the accumulator
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      done_r <= 1'b0;
      illegal_r <= 1'b0;
      dest_r <= 5'h00;
      dest_data_r <= 32'h0000_0000;
    end else begin
      done_r <= take_ok; // RULE15
      illegal_r <= take && !well_formed;
      if (take_ok) begin
        dest_r <= bus.mac_instr[DEST_LSB +: DEST_W];
        dest_data_r <= upper_dest_select ? result[63:32] : result[31:0]; // RULE7
      end
    end
  end

  // ==========================================================
  // Hazard spacing
  assign haz_cnt_nxt = mau_count_next(bus.acc_valid, bus.acc_op, haz_cnt_r);
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      haz_cnt_r <= 7'h00;
      ready_r <= 1'b0;
    end else begin
      haz_cnt_r <= haz_cnt_nxt; // RULE13 RULE14
      ready_r <= (haz_cnt_nxt == 7'h00); // RULE13 RULE14
    end
  end

  // ==========================================================
  // Outputs
  assign bus.mac_ready = ready_r;
  assign bus.mac_done = done_r;
  assign bus.mac_dest = dest_r;
  assign bus.mac_dest_data = dest_data_r;
  assign bus.mac_illegal = illegal_r;
  // No exception path exists for any result size
  assign bus.ovf_exc = 1'b0; // RULE8
  assign bus.acc_upper_word = upper_r;
  assign bus.acc_bottom_word = bottom_r;
  assign acc_upper_word = upper_r;
  assign acc_bottom_word = bottom_r;

endmodule

// *** rtl/mau_issue.sv ***
// Issuing end: spaces accumulator instructions ahead of each accumulate
`timescale 1ns/1ns
module mau_issue
  import mau_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  mau_if.issuer bus,
  input wire logic req_valid,
  input wire logic req_is_mac,
  input wire mau_acc_op_type req_acc_op,
  input wire logic [31:0] req_instr,
  input wire logic [31:0] req_src_a,
  input wire logic [31:0] req_src_b,
  input wire logic [31:0] req_wr_data,
  output logic req_ready,
  output logic res_valid,
  output logic [4:0] res_dest,
  output logic [31:0] res_data
);

  typedef enum logic [1:0] {
    PS_IDLE = 2'b00,
    PS_ACC = 2'b01,
    PS_WAIT = 2'b10,
    PS_ISSUE = 2'b11
  } mau_issue_state_type;

  mau_issue_state_type state_r;
  logic [6:0] cnt_r;
  logic ready_r;
  logic acc_valid_r;
  mau_acc_op_type acc_op_r;
  logic mac_valid_r;
  logic [31:0] instr_r;
  logic [31:0] a_r;
  logic [31:0] b_r;
  logic [31:0] wr_r;
  logic res_valid_r;
  logic [4:0] res_dest_r;
  logic [31:0] res_data_r;
  logic accept;
  assign accept = req_valid && ready_r;

  // ==========================================================
  // Sequencer
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_r <= PS_IDLE;
      ready_r <= 1'b0;
      acc_valid_r <= 1'b0;
      mac_valid_r <= 1'b0;
      acc_op_r <= ACC_WRITE_BOTTOM_ACC;
      instr_r <= 32'h0000_0000;
      a_r <= 32'h0000_0000;
      b_r <= 32'h0000_0000;
      wr_r <= 32'h0000_0000;
    end else begin
      unique case (state_r)
        PS_IDLE: begin
          ready_r <= 1'b1;
          if (accept) begin
            ready_r <= 1'b0;
            instr_r <= req_instr;
            a_r <= req_src_a;
            b_r <= req_src_b;
            acc_op_r <= req_acc_op;
            wr_r <= req_wr_data;
            acc_valid_r <= !req_is_mac;
            state_r <= req_is_mac ? PS_WAIT : PS_ACC;
          end
        end
        PS_ACC: begin
          acc_valid_r <= 1'b0;
          ready_r <= 1'b1;
          state_r <= PS_IDLE;
        end
        PS_WAIT: begin
          // Held back until the owed spacing has run out
          if (cnt_r == 7'h00) begin
            mac_valid_r <= 1'b1; // RULE13 RULE14
            state_r <= PS_ISSUE;
          end
        end
        PS_ISSUE: begin
          if (bus.mac_ready) begin
            mac_valid_r <= 1'b0;
            ready_r <= 1'b1;
            state_r <= PS_IDLE;
          end
        end
      endcase
    end
  end

  // ==========================================================
  // Spacing owed to the unit
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cnt_r <= 7'h00;
    end else begin
      cnt_r <= mau_count_next(acc_valid_r, acc_op_r, cnt_r); // RULE13 RULE14
    end
  end

  // ==========================================================
  // Results
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      res_valid_r <= 1'b0;
      res_dest_r <= 5'h00;
      res_data_r <= 32'h0000_0000;
    end else begin
      res_valid_r <= bus.mac_done;
      if (bus.mac_done) begin
        res_dest_r <= bus.mac_dest;
        res_data_r <= bus.mac_dest_data; // RULE7
      end
    end
  end

  assign bus.mac_valid = mac_valid_r;
  assign bus.mac_instr = instr_r;
  assign bus.mac_src_a = a_r;
  assign bus.mac_src_b = b_r;
  assign bus.acc_valid = acc_valid_r;
  assign bus.acc_op = acc_op_r;
  assign bus.acc_wr_data = wr_r;
  assign req_ready = ready_r;
  assign res_valid = res_valid_r;
  assign res_dest = res_dest_r;
  assign res_data = res_data_r;

endmodule

// *** sim/mau_asserts.sv ***
// Concurrent checks on the multiply-accumulate link
`timescale 1ns/1ns
module mau_asserts
  import mau_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic mac_valid,
  input wire logic [31:0] mac_instr,
  input wire logic [31:0] mac_src_a,
  input wire logic [31:0] mac_src_b,
  input wire logic mac_ready,
  input wire logic acc_valid,
  input wire mau_acc_op_type acc_op,
  input wire logic mac_done,
  input wire logic [4:0] mac_dest,
  input wire logic [31:0] mac_dest_data,
  input wire logic mac_illegal,
  input wire logic ovf_exc,
  input wire logic [31:0] acc_upper_word,
  input wire logic [31:0] acc_bottom_word
);
  // ==========================================================
  // Reference arithmetic; the bench keeps its own copy as exp_acc
  function automatic logic [63:0] mac_exp(input logic [31:0] i, input logic [31:0] a, input logic [31:0] b,
                                          input logic [63:0] acc);
    logic [63:0] p;
    logic [32:0] s;
    logic u;
    u = i[6];
    if (!i[10]) begin
      return {{32{a[31] & !u}}, a} * {{32{b[31] & !u}}, b} + acc;
    end
    p = {{48{a[15] & !u}}, a[15:0]} * {{48{b[15] & !u}}, b[15:0]};
    s = {p[31] & !u, p[31:0]} + {acc[31] & !u, acc[31:0]};
    if (u) begin
      return s[32] ? CLAMP_UNSIGNED_OVF : {32'h0000_0000, s[31:0]};
    end
    if (s[32:31] == 2'b01) begin
      return CLAMP_SIGNED_OVF;
    end
    if (s[32:31] == 2'b10) begin
      return CLAMP_SIGNED_UNF;
    end
    return {{32{s[31]}}, s[31:0]};
  endfunction

  // ==========================================================
  // Helper logic
  logic [6:0] gap_r;
  logic ok;
  logic take;
  logic [63:0] exp_w;
  assign ok = mac_instr[5:0] == FUNCT_MUL_ACC && mac_instr[8:7] == 2'b00;
  assign take = mac_valid && mac_ready && !acc_valid;
  assign exp_w = mac_exp(mac_instr, mac_src_a, mac_src_b, {acc_upper_word, acc_bottom_word});

  // Own spacing count, kept apart from the design's table
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      gap_r <= 7'h00;
    end else if (acc_valid) begin
      case (acc_op)
        ACC_SIGNED_MULTIPLY_32: gap_r <= 7'h01;
        ACC_DOUBLEWORD_MULTIPLY: gap_r <= 7'h03;
        ACC_DIVIDE_32: gap_r <= 7'h24;
        ACC_DOUBLEWORD_DIVIDE: gap_r <= 7'h44;
        ACC_READ_UPPER_ACC, ACC_READ_BOTTOM_ACC: gap_r <= 7'h02;
        default: gap_r <= 7'h00;
      endcase
    end else if (gap_r != 7'h00) begin
      gap_r <= gap_r - 7'h01;
    end
  end

  // ==========================================================
  // Properties
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence s_finish;
    ##1 (mac_done && !mac_illegal);
  endsequence

  a_no_overflow: assert property (!ovf_exc)
    else $error("overflow exception raised");
  a_plain_sum: assert property (take && ok && !mac_instr[10] |=> {acc_upper_word, acc_bottom_word} == $past(exp_w))
    else $error("plain accumulate result wrong");
  a_clamp_sum: assert property (take && ok && mac_instr[10] |=> {acc_upper_word, acc_bottom_word} == $past(exp_w))
    else $error("clamped accumulate result wrong");
  a_done_pulse: assert property (take && ok |-> s_finish)
    else $error("accumulate did not complete next cycle");
  a_illegal_quiet: assert property (take && !ok |=> mac_illegal && !mac_done && $stable(acc_bottom_word))
    else $error("bad instruction word not refused");
  a_dest_select: assert property (mac_done |-> mac_dest == $past(mac_instr[15:11]) &&
    mac_dest_data == ($past(mac_instr[9]) ? acc_upper_word : acc_bottom_word))
    else $error("destination value wrong");
  a_hold_words: assert property (!acc_valid && !(take && ok) |=> $stable(acc_upper_word) && $stable(acc_bottom_word))
    else $error("accumulator changed without an operation");
  a_ready_spacing: assert property (!$past(rst) |-> mac_ready == (gap_r == 7'h00))
    else $error("ready does not match hazard spacing");
  a_issue_spacing: assert property (mac_valid |-> gap_r == 7'h00)
    else $error("accumulate raised while spacing runs");
endmodule

// *** sim/testbench.sv ***
// Self-checking bench for issuer and unit joined back to back
`timescale 1ns/1ns
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin bad_count++; $display("unexpected %s exp %h got %h", n, e, s); end end
module testbench;
  import mau_pkg::*;
  logic sys_clk, rst, req_valid, req_is_mac, req_ready, res_valid;
  mau_acc_op_type req_acc_op;
  logic [31:0] req_instr, req_src_a, req_src_b, req_wr_data, res_data, acc_upper_word, acc_bottom_word, lfsr_r, t;
  logic [4:0] res_dest;
  logic [63:0] acc_m;
  logic [98:0] corner [6];
  int bad_count, comparisons;

  // ==========================================================
  // Structure
  mau_if u_bus();
  mau_core u_mau_core(.sys_clk(sys_clk), .rst(rst), .bus(u_bus), .acc_upper_word(acc_upper_word),
    .acc_bottom_word(acc_bottom_word));
  mau_issue u_mau_issue(.sys_clk(sys_clk), .rst(rst), .bus(u_bus), .req_valid(req_valid), .req_is_mac(req_is_mac),
    .req_acc_op(req_acc_op), .req_instr(req_instr), .req_src_a(req_src_a), .req_src_b(req_src_b),
    .req_wr_data(req_wr_data), .req_ready(req_ready), .res_valid(res_valid), .res_dest(res_dest), .res_data(res_data));
  mau_asserts u_mau_asserts(.sys_clk(sys_clk), .rst(rst), .mac_valid(u_bus.mac_valid), .mac_instr(u_bus.mac_instr),
    .mac_src_a(u_bus.mac_src_a), .mac_src_b(u_bus.mac_src_b), .mac_ready(u_bus.mac_ready),
    .acc_valid(u_bus.acc_valid), .acc_op(u_bus.acc_op), .mac_done(u_bus.mac_done), .mac_dest(u_bus.mac_dest),
    .mac_dest_data(u_bus.mac_dest_data), .mac_illegal(u_bus.mac_illegal), .ovf_exc(u_bus.ovf_exc),
    .acc_upper_word(u_bus.acc_upper_word), .acc_bottom_word(u_bus.acc_bottom_word));

  // ==========================================================
  // Helpers
  function automatic logic [31:0] rnd();
    lfsr_r = {lfsr_r[30:0], lfsr_r[31] ^ lfsr_r[21] ^ lfsr_r[1] ^ lfsr_r[0]};
    return lfsr_r;
  endfunction

  // Expected accumulator pair after one accumulate
  function automatic logic [63:0] exp_acc(input logic [31:0] i, input logic [31:0] a, input logic [31:0] b,
                                          input logic [63:0] acc);
    logic [63:0] p;
    logic [32:0] s;
    logic u;
    u = i[UNSIGNED_SELECT_BIT];
    if (!i[SAT_SELECT_BIT]) begin
      return {{32{a[31] & !u}}, a} * {{32{b[31] & !u}}, b} + acc;
    end
    p = {{48{a[15] & !u}}, a[15:0]} * {{48{b[15] & !u}}, b[15:0]};
    s = {p[31] & !u, p[31:0]} + {acc[31] & !u, acc[31:0]};
    if (u) begin
      return s[32] ? CLAMP_UNSIGNED_OVF : {32'h0000_0000, s[31:0]};
    end
    if (s[32:31] == 2'b01) begin
      return CLAMP_SIGNED_OVF;
    end
    if (s[32:31] == 2'b10) begin
      return CLAMP_SIGNED_UNF;
    end
    return {{32{s[31]}}, s[31:0]};
  endfunction

  // Bounded, so a stuck handshake falls to the watchdog
  task automatic wait_ready();
    int n;
    n = 0;
    @(negedge sys_clk);
    while (req_ready !== 1'b1 && n < 300) begin
      @(negedge sys_clk);
      n++;
    end
  endtask

  task automatic req(input logic m, input mau_acc_op_type op, input logic [31:0] i, input logic [31:0] a,
                     input logic [31:0] b, input logic [31:0] d);
    wait_ready();
    @(posedge sys_clk);
    req_valid <= 1'b1;
    req_is_mac <= m;
    req_acc_op <= op;
    req_instr <= i;
    req_src_a <= a;
    req_src_b <= b;
    req_wr_data <= d;
    @(posedge sys_clk);
    req_valid <= 1'b0;
    wait_ready();
    @(negedge sys_clk);
  endtask

  task automatic wr(input logic up, input logic [31:0] d);
    req(1'b0, up ? ACC_WRITE_UPPER_ACC : ACC_WRITE_BOTTOM_ACC, '0, '0, '0, d);
    if (up) begin
      acc_m[63:32] = d;
    end else begin
      acc_m[31:0] = d;
    end
  endtask

  task automatic mac(input logic [2:0] v, input logic [31:0] a, input logic [31:0] b);
    logic [31:0] i;
    logic [63:0] e;
    if (v[2]) begin
      a = {{16{a[15] & !v[0]}}, a[15:0]};
      b = {{16{b[15] & !v[0]}}, b[15:0]};
      wr(1'b1, {32{acc_m[31] & !v[0]}});
    end
    i = {16'h0000, lfsr_r[4:0], v[2], v[1], 2'b00, v[0], FUNCT_MUL_ACC};
    e = exp_acc(i, a, b, acc_m);
    acc_m = e;
    req(1'b1, ACC_WRITE_BOTTOM_ACC, i, a, b, '0);
    `CHK("res_valid", 1'b1, res_valid)
    `CHK("res_data", (v[1] ? e[63:32] : e[31:0]), res_data)
    `CHK("res_dest", i[15:11], res_dest)
    `CHK("acc", acc_m, {acc_upper_word, acc_bottom_word})
  endtask

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // ==========================================================
  // Clock, watchdog, sequence
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  initial begin
    repeat (20000) @(posedge sys_clk);
    bad_count++;
    end_of_test();
  end

  initial begin
    rst = 1'b1;
    {req_valid, req_is_mac, req_instr, req_src_a, req_src_b, req_wr_data} = '0;
    req_acc_op = ACC_WRITE_UPPER_ACC;
    lfsr_r = 32'hb059aab6;
    acc_m = '0;
    bad_count = 0;
    comparisons = 0;
    // Operation, bottom, a, b: clamp limits and plain wrap
    corner = '{{3'b100, 32'h7fff_0000, 32'h0000_7fff, 32'h0000_7fff}, {3'b110, 32'h8000_0000, 32'hffff_ffff, 32'h1},
      {3'b101, 32'hffff_ffff, 32'h1, 32'h1}, {3'b111, 32'h0, 32'h0000_ffff, 32'h0000_ffff},
      {3'b011, 32'hffff_ffff, 32'hffff_ffff, 32'hffff_ffff}, {3'b000, 32'h0, 32'h8000_0000, 32'h8000_0000}};
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    // Each accumulator op before an accumulate, straight before it for variants 0-3 only (4-7 write upper first), each variant once
    for (int k = 0; k < 8; k++) begin
      t = rnd();
      req(1'b0, mau_acc_op_type'(k), '0, '0, '0, t);
      if (k >= 6) begin
        acc_m[((k == 6) ? 63 : 31) -: 32] = t;
      end
      mac(k[2:0], rnd(), rnd());
    end
    $display("test spacing done");
    for (int k = 0; k < 6; k++) begin
      wr(1'b0, corner[k][95:64]);
      wr(1'b1, 32'hffff_ffff);
      mac(corner[k][98:96], corner[k][63:32], corner[k][31:0]);
    end
    $display("test corners done");
    for (int k = 0; k < 40; k++) begin
      t = rnd();
      mac(t[2:0], rnd(), rnd());
    end
    $display("test random done");
    req(1'b1, ACC_WRITE_UPPER_ACC, 32'h0000_01a8, 32'h5, 32'h7, '0);
    req(1'b1, ACC_WRITE_UPPER_ACC, 32'h0000_0029, 32'h5, 32'h7, '0);
    `CHK("acc", acc_m, {acc_upper_word, acc_bottom_word})
    `CHK("res_valid", 1'b0, res_valid)
    $display("test refusal done");
    end_of_test();
  end
endmodule
